/* hdl/analog_node_reset_config.sv */
/*
 * Analogue node configuration registers and system / tile reset generation.
 * Assumes configuration read and write requests decoded from link packets,
 * one request per cycle, and reset sources that are asynchronous to the clock.
 */
//
// Functional notes
// - Lock bit blocks setup and link writes
// - Setup bit 0 selects header size
// - Sixteen-bit node identifier, resets to zero
// - Pin, brownout, watchdog raise system reset
// - System reset wide; tile reset tile only
// - System reset lasts 524,288 oscillator cycles
// - Write bit 1 starts tile reset
// - Write bit 0 starts system reset
// - Reset writes never send a response
// - Mode pins bits 17:16, tristate bit 24
// - Frequency field 6:0, resets to 25
// - Out-of-range frequency ignored and negatively acknowledged
// - Tile reset and ticks follow frequency
`timescale 1ns/100ps
module analog_node_reset_config
  import anode_cfg_pkg::*;
#(
  parameter logic [19:0] SYS_RST_LEN = SYS_RST_CYCLES
)(
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_b,
  input  wire logic              i_cfg_valid,
  input  wire logic              i_cfg_write,
  input  wire logic              i_cfg_resp_req,
  input  wire logic [ADDR_W-1:0] i_cfg_addr,
  input  wire logic [31:0]       i_cfg_wdata,
  input  wire logic              i_ext_rst_b,
  input  wire logic              i_brownout,
  input  wire logic              i_wdog_expire,
  input  wire logic              i_sleep_seq,
  input  wire logic              i_clk_src_change,
  output logic                   o_cfg_ack,
  output logic                   o_cfg_nack,
  output logic [31:0]            o_cfg_rdata,
  output logic                   o_hdr_one_byte,
  output logic [15:0]            o_node_ident,
  output logic                   o_link_ctrl_locked,
  output logic [1:0]             o_mode_pins,
  output logic                   o_mode_pins_oe,
  output logic [6:0]             o_osc_freq_mhz,
  output logic                   o_ms_tick,
  output logic                   o_sys_rst_b,
  output logic                   o_tile_rst_b
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset source synchronisers

  logic [SRC_N-1:0] src_raw;
  logic [SRC_N-1:0] src_meta;
  logic [SRC_N-1:0] src_sync;

  assign src_raw = {i_clk_src_change, i_sleep_seq, i_wdog_expire, i_brownout, i_ext_rst_b};

  // Reset to zero: the pin lane then reads as asserted, so power-up gives a full reset
  for (genvar g = 0; g < SRC_N; g++) begin : g_sync
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        src_meta[g] <= 1'h0;
        src_sync[g] <= 1'h0;
      end else begin
        src_meta[g] <= src_raw[g];
        src_sync[g] <= src_meta[g];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request decode

  logic wr_setup;
  logic wr_ident;
  logic wr_reset;
  logic wr_freq;
  logic hit;
  logic freq_ok;
  logic rst_write;
  logic sys_active;
  logic tile_active;
  logic lock;
  logic hdr_mode;
  logic [15:0] ident;
  logic [1:0]  mode_pins;
  logic        mode_tri;
  logic [6:0]  freq;

  assign hit = (i_cfg_addr == REG_NODE_SETUP) || (i_cfg_addr == REG_NODE_IDENT) ||
               (i_cfg_addr == REG_RESET_MODE) || (i_cfg_addr == REG_OSC_FREQ);
  // Writes are dropped while the system reset holds the registers
  assign wr_setup = i_cfg_valid && i_cfg_write && !sys_active &&
                    (i_cfg_addr == REG_NODE_SETUP) && !lock;
  assign wr_ident = i_cfg_valid && i_cfg_write && !sys_active && (i_cfg_addr == REG_NODE_IDENT);
  assign wr_reset = i_cfg_valid && i_cfg_write && !sys_active && (i_cfg_addr == REG_RESET_MODE);
  assign freq_ok  = (i_cfg_wdata >= FREQ_MIN) && (i_cfg_wdata <= FREQ_MAX);
  assign wr_freq  = i_cfg_valid && i_cfg_write && !sys_active &&
                    (i_cfg_addr == REG_OSC_FREQ) && freq_ok;
  // Silent even while a system reset runs and the write itself is dropped
  assign rst_write = i_cfg_valid && i_cfg_write && (i_cfg_addr == REG_RESET_MODE) &&
                     (i_cfg_wdata[RM_SYS_BIT] || i_cfg_wdata[RM_TILE_BIT]);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers, cleared by the system reset

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lock     <= 1'h0;
      hdr_mode <= HDR_RESET;
    end else if (sys_active) begin
      lock     <= 1'h0;
      hdr_mode <= HDR_RESET;
    end else if (wr_setup) begin
      lock     <= i_cfg_wdata[SETUP_LOCK_BIT];
      hdr_mode <= i_cfg_wdata[SETUP_HDR_BIT];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ident <= IDENT_RESET;
    end else if (sys_active) begin
      ident <= IDENT_RESET;
    end else if (wr_ident) begin
      ident <= i_cfg_wdata[IDENT_MSB:0];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_pins <= MODE_RESET;
      mode_tri  <= TRI_RESET;
    end else if (sys_active) begin
      mode_pins <= MODE_RESET;
      mode_tri  <= TRI_RESET;
    end else if (wr_reset) begin
      mode_pins <= i_cfg_wdata[RM_MODE_MSB:RM_MODE_LSB];
      mode_tri  <= i_cfg_wdata[RM_TRI_BIT];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      freq <= FREQ_RESET;
    end else if (sys_active) begin
      freq <= FREQ_RESET;
    end else if (wr_freq) begin
      freq <= i_cfg_wdata[FREQ_MSB:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Responses: one cycle after the request, only for this block's registers

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cfg_ack  <= 1'h0;
      o_cfg_nack <= 1'h0;
    end else begin
      o_cfg_ack  <= 1'h0;
      o_cfg_nack <= 1'h0;
      if (i_cfg_valid && hit && i_cfg_resp_req && !rst_write) begin
        if (!i_cfg_write) begin
          o_cfg_ack  <= 1'h1;
        end else if (sys_active || (!freq_ok && i_cfg_addr == REG_OSC_FREQ) ||
                     (lock && i_cfg_addr == REG_NODE_SETUP)) begin
          o_cfg_nack <= 1'h1;
        end else begin
          o_cfg_ack  <= 1'h1;
        end
      end
    end
  end

  // Reset bits are write-only and read back as zero, so they self-clear
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cfg_rdata <= 32'h0000_0000;
    end else if (i_cfg_valid && !i_cfg_write) begin
      o_cfg_rdata <= 32'h0000_0000;
      unique case (i_cfg_addr)
        REG_NODE_SETUP: begin
          o_cfg_rdata[SETUP_LOCK_BIT] <= lock;
          o_cfg_rdata[SETUP_HDR_BIT]  <= hdr_mode;
        end
        REG_NODE_IDENT: o_cfg_rdata[IDENT_MSB:0] <= ident;
        REG_RESET_MODE: begin
          o_cfg_rdata[RM_MODE_MSB:RM_MODE_LSB] <= mode_pins;
          o_cfg_rdata[RM_TRI_BIT]              <= mode_tri;
        end
        REG_OSC_FREQ:   o_cfg_rdata[FREQ_MSB:0] <= freq;
        default:        o_cfg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset generation

  rst_timer_if sys_if ();
  rst_timer_if tile_if ();

  assign sys_if.length = SYS_RST_LEN;
  assign sys_if.start  = !src_sync[SRC_EXT_B] || src_sync[SRC_BROWNOUT] ||
                         src_sync[SRC_WDOG] ||
                         (wr_reset && i_cfg_wdata[RM_SYS_BIT]);
  // Tile reset length scales with the programmed oscillator frequency
  assign tile_if.length = CNT_W'(freq * TILE_RST_US);
  assign tile_if.start  = src_sync[SRC_SLEEP] || src_sync[SRC_CLKCHG] ||
                          (wr_reset && i_cfg_wdata[RM_TILE_BIT]);

  reset_timer u_sys_timer (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .tmr       (sys_if)
  );

  reset_timer u_tile_timer (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .tmr       (tile_if)
  );

  assign sys_active  = sys_if.active;
  assign tile_active = tile_if.active;

  // A system reset also holds the tile; a tile reset leaves the system alone
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sys_rst_b  <= 1'h0;
      o_tile_rst_b <= 1'h0;
    end else begin
      // Start counts as active, else both outputs blink high on the first edge after power-on
      o_sys_rst_b  <= !(sys_active || sys_if.start);
      o_tile_rst_b <= !(sys_active || sys_if.start || tile_active);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick for watchdog and sleep clock, from the frequency setting

  logic [MS_W-1:0] ms_count;
  logic [MS_W-1:0] ms_limit;

  assign ms_limit = MS_W'(freq * US_PER_MS) - 17'h00001;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ms_count  <= '0;
      o_ms_tick <= 1'h0;
    end else if (ms_count >= ms_limit) begin
      ms_count  <= '0;
      o_ms_tick <= 1'h1;
    end else begin
      ms_count  <= ms_count + 17'h00001;
      o_ms_tick <= 1'h0;
    end
  end

  assign o_hdr_one_byte     = hdr_mode;
  assign o_node_ident       = ident;
  assign o_link_ctrl_locked = lock;
  assign o_mode_pins        = mode_pins;
  assign o_mode_pins_oe     = !mode_tri;
  assign o_osc_freq_mhz     = freq;
endmodule : analog_node_reset_config

/* hdl/reset_timer.sv */
/*
 * Retriggerable reset length counter.
 * Assumes length is stable while start is high; runs on the oscillator clock.
 */
`timescale 1ns/100ps
module reset_timer
  import anode_cfg_pkg::*;
(
  input  wire logic  i_ref_clk,
  input  wire logic  i_rst_b,
  rst_timer_if.timer tmr
);
  logic [CNT_W-1:0] count;

  // Active for exactly length cycles after the last start
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count <= '0;
    end else if (tmr.start) begin
      count <= tmr.length;
    end else if (count != '0) begin
      count <= count - 20'h00001;
    end
  end

  assign tmr.active = (count != '0);
endmodule : reset_timer

/* inc/anode_cfg_pkg.sv */
/*
 * Shared constants for the analogue node configuration and reset block:
 * register numbers, field positions, reset values and timing counts.
 * Assumes register numbers arrive unscaled on the configuration request port.
 */
package anode_cfg_pkg;
  localparam int unsigned ADDR_W          = 16;
  localparam int unsigned CNT_W           = 20;
  localparam int unsigned MS_W            = 17;

  // Register numbers as carried in configuration packets
  localparam logic [15:0] REG_NODE_SETUP  = 16'h0004;
  localparam logic [15:0] REG_NODE_IDENT  = 16'h0005;
  localparam logic [15:0] REG_RESET_MODE  = 16'h0050;
  localparam logic [15:0] REG_OSC_FREQ    = 16'h0051;

  // Field positions
  localparam int unsigned SETUP_LOCK_BIT  = 31;
  localparam int unsigned SETUP_HDR_BIT   = 0;
  localparam int unsigned IDENT_MSB       = 15;
  localparam int unsigned RM_SYS_BIT      = 0;
  localparam int unsigned RM_TILE_BIT     = 1;
  localparam int unsigned RM_MODE_LSB     = 16;
  localparam int unsigned RM_MODE_MSB     = 17;
  localparam int unsigned RM_TRI_BIT      = 24;
  localparam int unsigned FREQ_MSB        = 6;

  // Reset values and accepted frequency range
  localparam logic        HDR_RESET       = 1'h0;
  localparam logic [15:0] IDENT_RESET     = 16'h0000;
  localparam logic [1:0]  MODE_RESET      = 2'h0;
  localparam logic        TRI_RESET       = 1'h0;
  localparam logic [6:0]  FREQ_RESET      = 7'h19;
  localparam logic [31:0] FREQ_MIN        = 32'h0000_0005;
  localparam logic [31:0] FREQ_MAX        = 32'h0000_0064;

  // Timing
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam logic [19:0] SYS_RST_CYCLES  = 20'h8_0000;
  localparam int unsigned TILE_RST_US     = 64;
  localparam int unsigned US_PER_MS       = 1000;

  // Synchroniser lanes for the reset sources
  localparam int unsigned SRC_N           = 5;
  localparam int unsigned SRC_EXT_B       = 0;
  localparam int unsigned SRC_BROWNOUT    = 1;
  localparam int unsigned SRC_WDOG        = 2;
  localparam int unsigned SRC_SLEEP       = 3;
  localparam int unsigned SRC_CLKCHG      = 4;
endpackage : anode_cfg_pkg

/* inc/rst_timer_if.sv */
/*
 * Carrier between the reset controller and a reset length timer.
 * Assumes both ends share the oscillator clock.
 */
`timescale 1ns/100ps
interface rst_timer_if;
  logic        start;
  logic [19:0] length;
  logic        active;

  modport owner (output start, output length, input active);
  modport timer (input start, input length, output active);
endinterface : rst_timer_if

/* tb/analog_node_reset_config_props.sv */
/* Checker for the configuration and reset block.
   Assumes only the top module ports and one clock domain. */
`timescale 1ns/100ps
module analog_node_reset_config_props
  import anode_cfg_pkg::*;
#(
  parameter logic [19:0] SYS_RST_LEN = SYS_RST_CYCLES
)(
  input wire logic              i_ref_clk,
  input wire logic              i_rst_b,
  input wire logic              i_cfg_valid,
  input wire logic              i_cfg_write,
  input wire logic              i_cfg_resp_req,
  input wire logic [ADDR_W-1:0] i_cfg_addr,
  input wire logic [31:0]       i_cfg_wdata,
  input wire logic              i_ext_rst_b,
  input wire logic              i_brownout,
  input wire logic              o_cfg_ack,
  input wire logic              o_cfg_nack,
  input wire logic              o_hdr_one_byte,
  input wire logic              o_link_ctrl_locked,
  input wire logic [6:0]        o_osc_freq_mhz,
  input wire logic              o_sys_rst_b,
  input wire logic              o_tile_rst_b
);
  logic [20:0] low_cnt;
  logic        wr_v;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  assign wr_v = i_cfg_valid && i_cfg_write;
  // Counts sampled low cycles of the system reset output
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) low_cnt <= 21'h0;
    else if (o_sys_rst_b) low_cnt <= 21'h0;
    else low_cnt <= low_cnt + 21'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  resp_excl_a: assert property (!(o_cfg_ack && o_cfg_nack)) else $error("ack with nack");
  resp_cause_a: assert property ((o_cfg_ack || o_cfg_nack) |->
    $past(i_cfg_valid && i_cfg_resp_req)) else $error("answer without request");
  rst_no_resp_a: assert property (wr_v && i_cfg_addr == REG_RESET_MODE &&
    i_cfg_wdata[1:0] != 2'h0 |=> !o_cfg_ack && !o_cfg_nack) else $error("reset write answered");
  freq_nack_a: assert property (wr_v && i_cfg_resp_req && i_cfg_addr == REG_OSC_FREQ &&
    (i_cfg_wdata < FREQ_MIN || i_cfg_wdata > FREQ_MAX) |=> o_cfg_nack && $stable(o_osc_freq_mhz))
    else $error("bad frequency taken");
  freq_valid_a: assert property (o_osc_freq_mhz inside {[7'h05:7'h64]})
    else $error("frequency out of range");
  lock_hold_a: assert property (o_link_ctrl_locked && o_sys_rst_b && wr_v &&
    i_cfg_addr == REG_NODE_SETUP |=> !o_sys_rst_b ||
    ($stable(o_hdr_one_byte) && o_link_ctrl_locked))
    else $error("locked setup changed");
  lock_sticky_a: assert property ($fell(o_link_ctrl_locked) |->
    !o_sys_rst_b || !$past(o_sys_rst_b)) else $error("lock lost without reset");
  tile_in_sys_a: assert property (!o_sys_rst_b |-> !o_tile_rst_b)
    else $error("tile free in system reset");
  tile_start_a: assert property (wr_v && i_cfg_addr == REG_RESET_MODE &&
    i_cfg_wdata[1] |-> ##[1:3] !o_tile_rst_b) else $error("tile reset not started");
  sys_start_a: assert property (wr_v && i_cfg_addr == REG_RESET_MODE &&
    i_cfg_wdata[0] |-> ##[1:3] !o_sys_rst_b) else $error("system reset not started");
  sys_len_a: assert property ($rose(o_sys_rst_b) |-> low_cnt >= SYS_RST_LEN)
    else $error("system reset too short");
  pin_sys_a: assert property ((!i_ext_rst_b || i_brownout) [*3] |->
    ##[0:6] !o_sys_rst_b) else $error("source ignored");
endmodule : analog_node_reset_config_props

bind analog_node_reset_config analog_node_reset_config_props #(.SYS_RST_LEN(SYS_RST_LEN))
  i_analog_node_reset_config_props (.i_ref_clk, .i_rst_b, .i_cfg_valid, .i_cfg_write,
  .i_cfg_resp_req, .i_cfg_addr, .i_cfg_wdata, .i_ext_rst_b, .i_brownout, .o_cfg_ack,
  .o_cfg_nack, .o_hdr_one_byte, .o_link_ctrl_locked, .o_osc_freq_mhz, .o_sys_rst_b,
  .o_tile_rst_b);

/* tb/analog_node_reset_config_test.sv */
/* Self-checking bench for the configuration and reset block.
   Assumes a shortened system reset length; requests come from the tile model. */
`timescale 1ns/100ps
module analog_node_reset_config_test;
  import anode_cfg_pkg::*;
  logic i_ref_clk, i_rst_b, ack, nack, ms_tick, hdr, locked, mode_oe, sys_b, tile_b;
  logic valid, write, resp_req;
  logic [15:0] addr, ident;
  logic [31:0] wdata, rdata;
  logic [1:0]  mode;
  logic [6:0]  freq;
  logic [4:0]  src;
  int          n_errors = 0, cmp_count = 0, cyc = 0;
  analog_node_reset_config #(.SYS_RST_LEN(20'h00040)) i_analog_node_reset_config (
    .i_ref_clk, .i_rst_b, .i_cfg_valid(valid), .i_cfg_write(write),
    .i_cfg_resp_req(resp_req), .i_cfg_addr(addr), .i_cfg_wdata(wdata),
    .i_ext_rst_b(~src[0]), .i_brownout(src[1]), .i_wdog_expire(src[2]),
    .i_sleep_seq(src[3]), .i_clk_src_change(src[4]), .o_cfg_ack(ack), .o_cfg_nack(nack),
    .o_cfg_rdata(rdata), .o_hdr_one_byte(hdr), .o_node_ident(ident),
    .o_link_ctrl_locked(locked), .o_mode_pins(mode), .o_mode_pins_oe(mode_oe),
    .o_osc_freq_mhz(freq), .o_ms_tick(ms_tick), .o_sys_rst_b(sys_b), .o_tile_rst_b(tile_b));
  cfg_tile_model i_cfg_tile_model (.i_ref_clk, .i_ack(ack), .i_nack(nack), .i_rdata(rdata),
    .o_valid(valid), .o_write(write), .o_resp_req(resp_req), .o_addr(addr), .o_wdata(wdata));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_ref_clk = 1'h0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      summarize();
    end
  end
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] exp);
    logic [1:0]  ans;
    logic [31:0] rd;
    i_cfg_tile_model.xfer(1'h1, a, d, ans, rd);
    chk("answer", {30'h0, ans}, {30'h0, exp});
  endtask : wr
  task rd(input logic [15:0] a, input logic [31:0] exp);
    logic [1:0]  ans;
    logic [31:0] v;
    i_cfg_tile_model.xfer(1'h0, a, 32'h0, ans, v);
    chk("read", v, exp);
    chk("read answer", {30'h0, ans}, 32'h2);
  endtask : rd
  // Waits until both reset outputs are released, bounded
  task wait_free();
    for (int i = 0; i < 3000 && !(sys_b === 1'h1 && tile_b === 1'h1); i++)
      @(negedge i_ref_clk);
    chk("released", {sys_b, tile_b}, 2'h3);
  endtask : wait_free
  ////////////////////////////////////////////////////////////////////////////
  task t_regs();
    rd(REG_NODE_SETUP, 32'h0);
    rd(REG_NODE_IDENT, 32'h0);
    rd(REG_OSC_FREQ, 32'h19);
    chk("oe", mode_oe, 1'h1);
    wr(REG_OSC_FREQ, 32'h4, 2'h1);
    wr(REG_OSC_FREQ, 32'h65, 2'h1);
    chk("freq", freq, 7'h19);
    wr(REG_OSC_FREQ, 32'h64, 2'h2);
    wr(REG_OSC_FREQ, 32'h5, 2'h2);
    rd(REG_OSC_FREQ, 32'h5);
    wr(REG_NODE_IDENT, 32'hFFFF_BEEF, 2'h2);
    rd(REG_NODE_IDENT, 32'h0000_BEEF);
    chk("ident", ident, 32'h0000_BEEF);
    wr(REG_RESET_MODE, 32'h0103_0000, 2'h2);
    chk("mode", {mode, mode_oe}, 3'h6);
    $display("test regs done");
  endtask : t_regs
  task t_lock_tile();
    int n;
    wr(REG_NODE_SETUP, 32'h8000_0001, 2'h2);
    wr(REG_NODE_SETUP, 32'h0, 2'h1);
    chk("setup", {hdr, locked}, 2'h3);
    wr(REG_RESET_MODE, 32'h0103_0002, 2'h0);
    n = 0;
    // Length follows the 5 MHz setting: 5 * 64 cycles
    // The tile output falls one edge after the write, so count only once it has fallen
    for (int i = 0; i < 700 && (n == 0 || tile_b !== 1'h1); i++) begin
      @(negedge i_ref_clk);
      n += (tile_b === 1'h0);
    end
    chk("tile len", n, 32'h0000_0140);
    // Tick period follows the 5 MHz setting: 5 * 1000 cycles
    for (int i = 0; i < 6000 && ms_tick !== 1'h1; i++) @(negedge i_ref_clk);
    n = 0;
    for (int i = 0; i < 6000 && (n == 0 || ms_tick !== 1'h1); i++) begin
      @(negedge i_ref_clk);
      n++;
    end
    chk("tick gap", n, 32'h0000_1388);
    chk("sys", sys_b, 1'h1);
    rd(REG_RESET_MODE, 32'h0103_0000);
    rd(REG_NODE_SETUP, 32'h8000_0001);
    $display("test lock and tile done");
  endtask : t_lock_tile
  task t_sys();
    wr(REG_RESET_MODE, 32'h1, 2'h0);
    repeat (4) @(negedge i_ref_clk);
    chk("sys low", sys_b, 1'h0);
    wait_free();
    rd(REG_NODE_SETUP, 32'h0);
    rd(REG_OSC_FREQ, 32'h19);
    for (int k = 0; k < 5; k++) begin
      src[k] = 1'h1;
      repeat (8) @(negedge i_ref_clk);
      src[k] = 1'h0;
      chk("source", {sys_b, tile_b}, (k < 3) ? 2'h0 : 2'h2);
      wait_free();
    end
    $display("test system done");
  endtask : t_sys
  task summarize();
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  initial begin
    i_rst_b = 1'h0;
    src = 5'h0;
    repeat (16) @(negedge i_ref_clk);
    i_rst_b = 1'h1;
    wait_free();
    t_regs();
    t_lock_tile();
    t_sys();
    summarize();
  end
endmodule : analog_node_reset_config_test

/* tb/cfg_tile_model.sv */
/* Processing tile model issuing configuration requests.
   Assumes one call of xfer at a time, from the bench's main sequence. */
`timescale 1ns/100ps
module cfg_tile_model
  import anode_cfg_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_ack,
  input  wire logic        i_nack,
  input  wire logic [31:0] i_rdata,
  output logic             o_valid,
  output logic             o_write,
  output logic             o_resp_req,
  output logic [15:0]      o_addr,
  output logic [31:0]      o_wdata
);
  initial begin
    o_valid = 1'h0;
    o_write = 1'h0;
    o_resp_req = 1'h0;
    o_addr = 16'h0;
    o_wdata = 32'h0;
  end
  // Always asks for a response so a silent reset write is really tested
  task xfer(input logic wr, input logic [15:0] a, input logic [31:0] d,
            output logic [1:0] ans, output logic [31:0] rd);
    @(negedge i_ref_clk);
    o_valid = 1'h1;
    o_write = wr;
    o_resp_req = 1'h1;
    o_addr = a;
    o_wdata = d;
    @(negedge i_ref_clk);
    ans = {i_ack, i_nack};
    rd = i_rdata;
    o_valid = 1'h0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask : xfer
endmodule : cfg_tile_model
